// *** verilog/hmrxs_map.vh ***
/*
 * register map, status word layout and frame thresholds of the
 * receive status and control block.
 * assumes: included by the design file only, by its bare name.
 */
`ifndef HMRXS_MAP_VH
`define HMRXS_MAP_VH

// ==========================================================
// register offsets (byte addresses, one word each)
`define HMRXS_A_STS_PORT  8'h00
`define HMRXS_A_FIFO_INF  8'h04
`define HMRXS_A_MAC_CTRL  8'h08
`define HMRXS_A_INTERRUPT_STATUS_REGISTER   8'h0c

// ==========================================================
// control register bits
`define HMRXS_C_RX_EN     0
`define HMRXS_C_PASS_BAD_FRAMES   1
`define HMRXS_C_SFLUSH    2
`define HMRXS_C_DFLUSH    3
`define HMRXS_CTRL_RST    2'b00

// ==========================================================
// interrupt status bits (write one to clear)
`define HMRXS_I_RXSTOP    0
`define HMRXS_I_RXERR     1

// ==========================================================
// status word fields
`define HMRXS_S_FILT      30
`define HMRXS_S_LEN_HI    29
`define HMRXS_S_LEN_LO    16
`define HMRXS_S_ES        15
`define HMRXS_S_BCAST     13
`define HMRXS_S_LENERR    12
`define HMRXS_S_RUNT      11
`define HMRXS_S_MCAST     10
`define HMRXS_S_LONG      7
`define HMRXS_S_LATECOL   6
`define HMRXS_S_FTYPE     5
`define HMRXS_S_WDOG      4
`define HMRXS_S_MIIERR    3
`define HMRXS_S_DRIB      2
`define HMRXS_S_CRC       1
`define HMRXS_S_RSV31     31
`define HMRXS_S_RSV14     14
`define HMRXS_S_RSV9      9
`define HMRXS_S_RSV8      8
`define HMRXS_S_RSV0      0

// ==========================================================
// frame thresholds in bytes or bits
`define HMRXS_RUNT_LEN    14'h0040
`define HMRXS_MAX_LEN     14'h05ee
`define HMRXS_TYPE_MIN    16'h05dc
`define HMRXS_HDR_LEN     14'h000e
`define HMRXS_OVERHEAD    17'h0_0012
`define HMRXS_WDOG_LEN    14'h0800
`define HMRXS_DRIB_MIN10  3'h3

`endif

// *** verilog/hmrxs_top.v ***
/*
 * receive status and control of the host mac: builds one status
 * word per frame, queues it in a flip-flop fifo for the host,
 * runs the receiver stop handshake and raises the error flags.
 * assumes: the mac side reports each frame by a one-cycle fr_done
 * pulse after its data sits in the data fifo, with the frame
 * facts valid beside it; the host uses a plain register port.
 * limits: the watchdog and too-long flags are judged from the
 * reported byte length alone, so the mac side must keep counting
 * past the limits rather than cut the frame; a status word pushed
 * into a full fifo is lost and only the error flag records it;
 * the flush strobes act only once the receiver has fully halted;
 * the length check assumes 18 bytes of header plus crc.
 */
// Design decisions made here: the plain strobed port and the placing of the registers.
//
// Behaviour
// RL1 - one status word pushed per stored frame
// RL2 - reserved status bits always read zero
// RL3 - bit 30 marks address filter fail
// RL4 - bits 29:16 carry frame byte length
// RL5 - bit 15 is or of 11,7,6,1
// RL6 - bit 13 marks broadcast destination
// RL7 - bit 12 marks length field mismatch
// RL8 - bit 11 marks frame under 64 bytes
// RL9 - runts dropped unless pass bad frames set
// RL10 - bit 10 marks multicast destination
// RL11 - bit 7 over 1518 bytes, no truncation
// RL12 - bit 6 marks late collision
// RL13 - bit 5 type over 1500, not short runts
// RL14 - bit 4 marks receive watchdog expiry
// RL15 - bit 3 marks receive error signalled
// RL16 - bit 2 dribble bits, gated by speed, collision
// RL17 - dribble without crc error is valid
// RL18 - bit 1 crc mismatch or receive error
// RL19 - host ignores crc bit on bad frames
// RL20 - host stops, flushes, restarts via enable
// RL21 - pulse stopped event once receiver halted
// RL22 - error flag on underruns or status overrun
// RL23 - receiver keeps running after error flag
`timescale 1ns/1ps
`include "hmrxs_map.vh"

module hmrxs_top #(
    parameter SDEPTH = 16,
    parameter SAW    = 4,
    parameter [13:0] WDOG_LEN = `HMRXS_WDOG_LEN
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst,
    // host register port
    input  wire [7:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [31:0] rdata_r,
    // frame report from the mac side
    input  wire        fr_done,
    input  wire [13:0] fr_len,
    input  wire [15:0] fr_lt,
    input  wire        fr_filt_fail,
    input  wire        fr_bcast,
    input  wire        fr_mcast,
    input  wire        fr_late_col,
    input  wire        fr_rx_er,
    input  wire        fr_crc_bad,
    input  wire [2:0]  fr_drib,
    input  wire        spd_10,
    input  wire        fr_active,
    input  wire        dfifo_underrun,
    // controls and events toward the data path
    output reg         rx_run_r,
    output reg         frame_drop_r,
    output reg         dfifo_flush_r,
    output reg         rx_stop_evt_r,
    output reg         rx_err_flag_r
);

    // ==========================================================
    // receiver state
    localparam [2:0] ST_RUN   = 3'b001;
    localparam [2:0] ST_DRAIN = 3'b010;
    localparam [2:0] ST_STOP  = 3'b100;

    // state and its next value
    reg  [2:0]        st_r;
    reg  [2:0]        st_nxt;

    // control bits as last written by the host
    reg               rx_en_r;
    reg               pass_bad_frames_r;

    // sticky flags of the interrupt status register
    reg               int_stop_r;
    reg               int_err_r;

    // ==========================================================
    // status fifo storage
    // one word per queued frame, oldest at rp_r
    reg  [31:0]       sfifo [0:SDEPTH-1];
    reg  [SAW-1:0]    wp_r;
    reg  [SAW-1:0]    rp_r;
    reg  [SAW:0]      cnt_r;

    // fifo state and register selects
    wire              s_empty;
    wire              s_full;
    wire              sel_sts;
    wire              sel_inf;
    wire              sel_ctrl;
    wire              sel_int;

    // ==========================================================
    // frame classification
    // per-frame classes
    wire              is_runt;
    wire              is_long;
    wire              is_wdog;
    wire              is_type;
    wire              len_err;
    wire              drib;
    wire              es;

    // length check, one bit wider so the sum cannot wrap
    wire [16:0]       lt_full;
    wire [16:0]       len_ext;

    // status word and fifo strobes
    wire [31:0]       sword;
    wire              accept;
    wire              push;
    wire              pop;
    wire              s_under;
    wire              s_over;

    // halt and flush strobes
    wire              stop_now;
    wire              sflush;

    // thresholds applied to the reported byte length; a frame of
    // 64 bytes or more has cleared the collision window
    assign is_runt = fr_len < `HMRXS_RUNT_LEN;          // RL8
    assign is_long = fr_len > `HMRXS_MAX_LEN;           // RL11
    assign is_wdog = fr_len > WDOG_LEN;                 // RL14

    // type frames only once the length field was seen at all
    assign is_type = (fr_lt > `HMRXS_TYPE_MIN) &&
                     !(fr_len < `HMRXS_HDR_LEN);        // RL13

    // a length field must cover the payload; short ones may be padded
    // type frames carry no length, so they never flag a mismatch
    assign lt_full = {1'b0, fr_lt} + `HMRXS_OVERHEAD;
    assign len_ext = {3'b000, fr_len};
    assign len_err = !(fr_lt > `HMRXS_TYPE_MIN) &&
                     ((lt_full > len_ext) ||
                      (!is_runt && (fr_len != `HMRXS_RUNT_LEN) &&
                       (lt_full != len_ext)));          // RL7

    // at 10 Mbps a few stray bits are line noise, not dribble
    assign drib = (fr_drib != 3'h0) &&
                  (!spd_10 || !(fr_drib < `HMRXS_DRIB_MIN10)) &&
                  !fr_late_col;                         // RL16

    assign es = is_runt | is_long | fr_late_col |
                fr_crc_bad | fr_rx_er;                  // RL5

    // ==========================================================
    // status word assembly, reserved positions tied low
    assign sword[`HMRXS_S_RSV31]    = 1'b0;             // RL2
    // filter result, byte length and error summary
    assign sword[`HMRXS_S_FILT]     = fr_filt_fail;     // RL3
    assign sword[`HMRXS_S_LEN_HI:`HMRXS_S_LEN_LO] = fr_len; // RL4
    assign sword[`HMRXS_S_ES]       = es;               // RL5
    assign sword[`HMRXS_S_RSV14]    = 1'b0;             // RL2
    // destination class and the length checks
    assign sword[`HMRXS_S_BCAST]    = fr_bcast;         // RL6
    assign sword[`HMRXS_S_LENERR]   = len_err;          // RL7
    assign sword[`HMRXS_S_RUNT]     = is_runt;          // RL8
    assign sword[`HMRXS_S_MCAST]    = fr_mcast;         // RL10
    assign sword[`HMRXS_S_RSV9:`HMRXS_S_RSV8] = 2'b00;  // RL2
    // size, collision and type class
    assign sword[`HMRXS_S_LONG]     = is_long;          // RL11
    assign sword[`HMRXS_S_LATECOL]  = fr_late_col;      // RL12
    assign sword[`HMRXS_S_FTYPE]    = is_type;          // RL13
    assign sword[`HMRXS_S_WDOG]     = is_wdog;          // RL14
    // errors seen on the line
    assign sword[`HMRXS_S_MIIERR]   = fr_rx_er;         // RL15
    assign sword[`HMRXS_S_DRIB]     = drib;             // RL16
    // crc bit is left raw on bad frames; the host discounts it
    assign sword[`HMRXS_S_CRC]      = fr_crc_bad | fr_rx_er; // RL18
    assign sword[`HMRXS_S_RSV0]     = 1'b0;             // RL2

    // ==========================================================
    // register decode; exact, so any other address reads zero
    // and ignores writes
    assign sel_sts  = addr == `HMRXS_A_STS_PORT;
    assign sel_inf  = addr == `HMRXS_A_FIFO_INF;
    assign sel_ctrl = addr == `HMRXS_A_MAC_CTRL;
    assign sel_int  = addr == `HMRXS_A_INTERRUPT_STATUS_REGISTER;

    // ==========================================================
    // fifo flow; dribble alone never drops a frame
    // a report in the halted state is ignored altogether
    assign s_empty  = cnt_r == {(SAW+1){1'b0}};
    assign s_full   = cnt_r == SDEPTH[SAW:0];
    assign accept   = fr_done && !st_r[2] &&
                      (!is_runt || pass_bad_frames_r);          // RL9 RL17
    assign sflush   = wr && sel_ctrl && st_r[2] &&
                      wdata[`HMRXS_C_SFLUSH];           // RL20
    assign push     = accept && !s_full && !sflush;     // RL1
    assign s_over   = accept && s_full;                 // RL22
    assign pop      = rd && sel_sts && !s_empty;
    assign s_under  = rd && sel_sts && s_empty;         // RL22
    assign stop_now = st_r[1] && !fr_active;            // RL21

    // ==========================================================
    // receiver stop handshake, frame in flight finishes first
    always @* begin
        st_nxt = st_r;
        case (st_r)
            ST_RUN: begin
                // enable cleared: the frame in flight may still finish
                if (!rx_en_r) begin
                    st_nxt = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                // halted once the mac side goes idle
                if (stop_now) begin
                    st_nxt = ST_STOP;
                end
            end
            ST_STOP: begin
                if (rx_en_r) begin
                    st_nxt = ST_RUN;
                end
            end
            default: begin
                // an illegal code parks the receiver halted
                st_nxt = ST_STOP;
            end
        endcase
    end

    // state register and receiver run level
    // run level follows the next state so both change together
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r     <= ST_STOP;
            rx_run_r <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            rx_run_r <= st_nxt == ST_RUN;
        end
    end

    // ==========================================================
    // control register; flush bits are self clearing strobes
    // pass bad frames reads back; the flush bits read as zero
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_en_r       <= 1'b0;
            pass_bad_frames_r     <= 1'b0;
            dfifo_flush_r <= 1'b0;
        end else begin
            dfifo_flush_r <= 1'b0;
            if (wr && sel_ctrl) begin
                rx_en_r   <= wdata[`HMRXS_C_RX_EN];     // RL20
                pass_bad_frames_r <= wdata[`HMRXS_C_PASS_BAD_FRAMES];
                // flushing a live receiver would tear frames
                dfifo_flush_r <= st_r[2] &&
                                 wdata[`HMRXS_C_DFLUSH]; // RL20
            end
        end
    end

    // ==========================================================
    // interrupt status flags; a new event beats the clear
    // the event pulse rises on the same edge that the halted state is entered
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            int_stop_r    <= 1'b0;
            int_err_r     <= 1'b0;
            rx_stop_evt_r <= 1'b0;
            rx_err_flag_r <= 1'b0;
        end else begin
            rx_stop_evt_r <= stop_now;                  // RL21
            // the halt sets the flag even against a clear
            if (stop_now) begin
                int_stop_r <= 1'b1;                     // RL21
            end else if (wr && sel_int &&
                         wdata[`HMRXS_I_RXSTOP]) begin
                int_stop_r <= 1'b0;
            end
            // error only flags; reception carries on regardless
            if (s_under || s_over || dfifo_underrun) begin
                int_err_r     <= 1'b1;                  // RL22 RL23
                rx_err_flag_r <= 1'b1;
            end else if (wr && sel_int &&
                         wdata[`HMRXS_I_RXERR]) begin
                int_err_r     <= 1'b0;
                rx_err_flag_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // runt drop strobe toward the data path
    // the data path discards the frame's stored data on it
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            frame_drop_r <= 1'b0;
        end else begin
            frame_drop_r <= fr_done && !st_r[2] &&
                            is_runt && !pass_bad_frames_r;      // RL9
        end
    end

    // ==========================================================
    // status fifo pointers; an overrun loses the newest word
    // pointers wrap by their width, so SDEPTH is a power of two
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_r  <= {SAW{1'b0}};
            rp_r  <= {SAW{1'b0}};
            cnt_r <= {(SAW+1){1'b0}};
        end else if (sflush) begin
            wp_r  <= {SAW{1'b0}};
            rp_r  <= {SAW{1'b0}};
            cnt_r <= {(SAW+1){1'b0}};
        end else begin
            if (push) begin
                wp_r <= wp_r + {{(SAW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rp_r <= rp_r + {{(SAW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + {{SAW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                cnt_r <= cnt_r - {{SAW{1'b0}}, 1'b1};
            end
        end
    end

    // storage has no reset; only written slots are ever read
    // a slot is written at the push edge and read at the pop edge
    always @(posedge clk) begin
        if (push) begin
            sfifo[wp_r] <= sword;                       // RL1
        end
    end

    // ==========================================================
    // read data, valid the cycle after the strobe only
    // an empty status read returns zero and raises the error flag
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= 32'h0000_0000;
            if (rd) begin
                if (pop) begin
                    rdata_r <= sfifo[rp_r];
                end else if (sel_inf) begin
                    rdata_r <= {{(31-SAW){1'b0}}, cnt_r};
                end else if (sel_ctrl) begin
                    rdata_r <= {30'h0000_0000, pass_bad_frames_r, rx_en_r};
                end else if (sel_int) begin
                    rdata_r <= {30'h0000_0000, int_err_r, int_stop_r};
                end
            end
        end
    end

endmodule

// *** tb/hmrxs_chk_asserts.sv ***
/*
 * checker of the receive status block: status word fields, runt drop,
 * receiver halt event and error flag.
 * assumes: bound to hmrxs_top, status port read at offset 0x00.
 */
`timescale 1ns/1ps
module hmrxs_chk (
    // clock and reset
    input wire        clk,
    input wire        rst,
    // host register port
    input wire [7:0]  addr,
    input wire [31:0] wdata,
    input wire        wr,
    input wire        rd,
    input wire [31:0] rdata_r,
    // frame report and controls
    input wire        fr_done,
    input wire [13:0] fr_len,
    input wire        fr_active,
    input wire        dfifo_underrun,
    input wire        rx_run_r,
    input wire        frame_drop_r,
    input wire        dfifo_flush_r,
    input wire        rx_stop_evt_r,
    input wire        rx_err_flag_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // status word; an empty-fifo read gives length zero, so skip it
    wire [13:0] len_w = rdata_r[29:16];
    wire        real_w = len_w != 14'h0000;
    sequence s_sts_rd;
        rd && addr == 8'h00;
    endsequence
    sequence s_drain;
        $fell(rx_run_r) && !fr_active;
    endsequence
    a_rsvd_zero : assert property (
        s_sts_rd |=> rdata_r[31] == 1'b0 && rdata_r[14] == 1'b0
            && rdata_r[9:8] == 2'h0 && rdata_r[0] == 1'b0) else $error("reserved bit set");
    a_err_sum : assert property (
        s_sts_rd |=> rdata_r[15] == (rdata_r[11] | rdata_r[7] | rdata_r[6] | rdata_r[1]))
        else $error("summary error bit wrong");
    a_runt_bit : assert property (
        s_sts_rd |=> !real_w || rdata_r[11] == (len_w < 14'h0040)) else $error("runt bit wrong");
    a_long_bit : assert property (
        s_sts_rd |=> !real_w || rdata_r[7] == (len_w > 14'h05ee)) else $error("long bit wrong");
    a_type_runt : assert property (
        s_sts_rd |=> !(len_w < 14'h000e && rdata_r[5])) else $error("type bit on short runt");
    a_drib_col : assert property (
        s_sts_rd |=> !(rdata_r[2] && rdata_r[6])) else $error("dribble with late collision");
    // ==========================================================
    // drop, halt and error flag
    a_drop_cause : assert property (
        frame_drop_r |-> $past(fr_done) && $past(fr_len) < 14'h0040) else $error("bad drop");
    a_halt_event : assert property (
        s_drain |-> ##[1:3] rx_stop_evt_r) else $error("no stop event");
    a_evt_pulse : assert property (
        rx_stop_evt_r |-> !rx_run_r ##1 !rx_stop_evt_r) else $error("stop event not a pulse");
    a_underrun_flag : assert property (
        dfifo_underrun |-> ##[1:2] rx_err_flag_r) else $error("underrun not flagged");
    a_err_keeps_run : assert property (
        $rose(rx_err_flag_r) && rx_run_r && !wr && !$past(wr) |=> rx_run_r)
        else $error("receiver stopped on error");
    a_flush_cause : assert property (
        dfifo_flush_r |-> $past(wr) && $past(addr) == 8'h08 && $past(wdata[3])
            && !$past(rx_run_r)) else $error("data flush without request");
endmodule
bind hmrxs_top hmrxs_chk hmrxs_chk_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_r(rdata_r), .fr_done(fr_done), .fr_len(fr_len),
    .fr_active(fr_active), .dfifo_underrun(dfifo_underrun), .rx_run_r(rx_run_r),
    .frame_drop_r(frame_drop_r), .dfifo_flush_r(dfifo_flush_r), .rx_stop_evt_r(rx_stop_evt_r),
    .rx_err_flag_r(rx_err_flag_r));

// *** tb/hmrxs_host.sv ***
/*
 * host processor model: single-cycle register writes and reads.
 * assumes: read data stands only in the cycle after the read strobe.
 */
`timescale 1ns/1ps
module hmrxs_host (
    // clock
    input wire        clk,
    // register port toward the block
    output reg [7:0]  addr,
    output reg [31:0] wdata,
    output reg        wr,
    output reg        rd,
    input wire [31:0] rdata_r
);
    // ==========================================================
    // bus idle values
    initial begin
        addr = 8'h00;
        wdata = 32'h0000_0000;
        wr = 1'b0;
        rd = 1'b0;
    end
    // write data is scrambled after use so a late sample shows up
    task wr_reg(input [7:0] a, input [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~d;
    endtask
    // sampled mid-cycle, where the answer has settled
    task rd_reg(input [7:0] a, output [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata_r;
    endtask
endmodule

// *** tb/testbench.sv ***
/*
 * testbench of the receive status block: frame table, runt drop,
 * error flag, overrun, halt, flush and restart.
 * assumes: hmrxs_top with default parameters, hmrxs_host as bus master.
 */
`timescale 1ns/1ps
module testbench;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg         fr_done = 1'b0, fr_filt_fail = 1'b0, fr_bcast = 1'b0, fr_mcast = 1'b0;
    reg         fr_late_col = 1'b0, fr_rx_er = 1'b0, fr_crc_bad = 1'b0, spd_10 = 1'b0;
    reg         fr_active = 1'b0, dfifo_underrun = 1'b0;
    reg  [13:0] fr_len = 14'h0000;
    reg  [15:0] fr_lt = 16'h0000;
    reg  [2:0]  fr_drib = 3'h0;
    wire [7:0]  addr;
    wire [31:0] wdata, rdata_r;
    wire        wr, rd, rx_run_r, frame_drop_r, dfifo_flush_r, rx_stop_evt_r, rx_err_flag_r;
    reg  [31:0] w;
    integer     error_cnt = 0, n_tests = 0, i;
    always #2 clk = ~clk;
    hmrxs_top hmrxs_top_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata_r(rdata_r), .fr_done(fr_done), .fr_len(fr_len), .fr_lt(fr_lt),
        .fr_filt_fail(fr_filt_fail), .fr_bcast(fr_bcast), .fr_mcast(fr_mcast),
        .fr_late_col(fr_late_col), .fr_rx_er(fr_rx_er), .fr_crc_bad(fr_crc_bad),
        .fr_drib(fr_drib), .spd_10(spd_10), .fr_active(fr_active),
        .dfifo_underrun(dfifo_underrun), .rx_run_r(rx_run_r), .frame_drop_r(frame_drop_r),
        .dfifo_flush_r(dfifo_flush_r), .rx_stop_evt_r(rx_stop_evt_r),
        .rx_err_flag_r(rx_err_flag_r));
    hmrxs_host hmrxs_host_inst (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_r(rdata_r));
    // ==========================================================
    // expected status word; f = filt,bcast,mcast,late,rxer,crc,10m
    function [31:0] exp_w(input [13:0] l, input [15:0] t, input [6:0] f, input [2:0] d);
        reg [16:0] s;
        reg        rn, lg, c, le;
        begin
            s = t + 17'h0_0012;
            rn = l < 14'h0040;
            lg = l > 14'h05ee;
            c = f[1] | f[2];
            le = t <= 16'h05dc && (s > l || (l > 14'h0040 && s != l));
            exp_w = {1'b0, f[6], l, rn | lg | f[3] | c, 1'b0, f[5], le, rn, f[4], 2'h0, lg,
                f[3], t > 16'h05dc && l >= 14'h000e, l > 14'h0800, f[2],
                d != 3'h0 && (!f[0] || d >= 3'h3) && !f[3], c, 1'b0};
        end
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chkb(input got, input exp);
        chk({31'h0000_0000, got}, {31'h0000_0000, exp});
    endtask
    task rdc(input [7:0] a, input [31:0] e);
        hmrxs_host_inst.rd_reg(a, w);
        chk(w, e);
    endtask
    task send(input [13:0] l, input [15:0] t, input [6:0] f, input [2:0] d);
        @(posedge clk);
        fr_len <= l;
        fr_lt <= t;
        {fr_filt_fail, fr_bcast, fr_mcast, fr_late_col, fr_rx_er, fr_crc_bad, spd_10} <= f;
        fr_drib <= d;
        fr_done <= 1'b1;
        @(posedge clk);
        fr_done <= 1'b0;
        #1;
    endtask
    task frame(input [13:0] l, input [15:0] t, input [6:0] f, input [2:0] d);
        send(l, t, f, d);
        rdc(8'h00, exp_w(l, t, f, d));
    endtask
    task complete_run;
        $display("errors %0d comparisons %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // watchdog well beyond the roughly 170 cycles the sequence needs
    initial begin
        #20000;
        error_cnt = error_cnt + 1;
        complete_run;
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rdc(8'h08, 32'h0000_0000);
        hmrxs_host_inst.wr_reg(8'h10, 32'hffff_ffff);
        rdc(8'h10, 32'h0000_0000);
        hmrxs_host_inst.wr_reg(8'h08, 32'h0000_0003);
        repeat (3) @(negedge clk);
        chkb(rx_run_r, 1'b1);
        frame(14'h0064, 16'h0052, 7'h60, 3'h0);
        frame(14'h0064, 16'h0050, 7'h10, 3'h0);
        frame(14'h0028, 16'h0800, 7'h02, 3'h0);
        frame(14'h000a, 16'h0800, 7'h00, 3'h0);
        frame(14'h0640, 16'h0800, 7'h00, 3'h0);
        frame(14'h0834, 16'h0800, 7'h00, 3'h0);
        frame(14'h0064, 16'h0052, 7'h04, 3'h0);
        frame(14'h0064, 16'h0052, 7'h02, 3'h0);
        frame(14'h0064, 16'h0052, 7'h01, 3'h2);
        frame(14'h0064, 16'h0052, 7'h01, 3'h3);
        frame(14'h0064, 16'h0052, 7'h00, 3'h2);
        frame(14'h0064, 16'h0052, 7'h08, 3'h3);
        // runt with pass bad frames off is dropped, nothing queued
        hmrxs_host_inst.wr_reg(8'h08, 32'h0000_0009);
        @(negedge clk);
        chkb(dfifo_flush_r, 1'b0);
        send(14'h0028, 16'h0800, 7'h00, 3'h0);
        chkb(frame_drop_r, 1'b1);
        rdc(8'h04, 32'h0000_0000);
        hmrxs_host_inst.wr_reg(8'h08, 32'h0000_0003);
        // empty status read, then data fifo underrun
        rdc(8'h00, 32'h0000_0000);
        rdc(8'h0c, 32'h0000_0002);
        chkb(rx_run_r, 1'b1);
        hmrxs_host_inst.wr_reg(8'h0c, 32'h0000_0003);
        rdc(8'h0c, 32'h0000_0000);
        @(posedge clk);
        dfifo_underrun <= 1'b1;
        @(posedge clk);
        dfifo_underrun <= 1'b0;
        repeat (2) @(negedge clk);
        chkb(rx_err_flag_r, 1'b1);
        hmrxs_host_inst.wr_reg(8'h0c, 32'h0000_0003);
        // one word more than the status fifo holds
        for (i = 0; i < 17; i = i + 1)
            send(14'h0064, 16'h0052, 7'h00, 3'h0);
        rdc(8'h04, 32'h0000_0010);
        rdc(8'h0c, 32'h0000_0002);
        hmrxs_host_inst.wr_reg(8'h0c, 32'h0000_0003);
        // halt while a frame is still arriving
        fr_active <= 1'b1;
        hmrxs_host_inst.wr_reg(8'h08, 32'h0000_0002);
        repeat (4) @(negedge clk);
        chkb(rx_stop_evt_r, 1'b0);
        fr_active <= 1'b0;
        for (i = 0; i < 20 && rx_stop_evt_r !== 1'b1; i = i + 1)
            @(negedge clk);
        chkb(rx_stop_evt_r, 1'b1);
        rdc(8'h0c, 32'h0000_0001);
        hmrxs_host_inst.wr_reg(8'h08, 32'h0000_000e);
        @(negedge clk);
        chkb(dfifo_flush_r, 1'b1);
        rdc(8'h04, 32'h0000_0000);
        send(14'h0064, 16'h0052, 7'h00, 3'h0);
        rdc(8'h04, 32'h0000_0000);
        hmrxs_host_inst.wr_reg(8'h08, 32'h0000_0003);
        repeat (3) @(negedge clk);
        frame(14'h0064, 16'h0052, 7'h40, 3'h0);
        // halt with the line idle: the event follows two edges on
        hmrxs_host_inst.wr_reg(8'h08, 32'h0000_0000);
        repeat (3) @(negedge clk);
        chkb(rx_stop_evt_r, 1'b1);
        complete_run;
    end
endmodule
